// File: logic/sbp_pkg.sv
`default_nettype none
package sbp_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [2:0] ADDR_RAMP1 = 3'h0;
  localparam logic [2:0] ADDR_COUNT1 = 3'h1;
  localparam logic [2:0] ADDR_RAMP2 = 3'h2;
  localparam logic [2:0] ADDR_COUNT2 = 3'h3;
  localparam logic [2:0] ADDR_CONFIG = 3'h4;
  localparam logic [7:0] RESET_RAMP1 = 8'h55;
  localparam logic [7:0] RESET_COUNT1 = 8'h55;
  localparam logic [7:0] RESET_RAMP2 = 8'h55;
  localparam logic [7:0] RESET_COUNT2 = 8'h00;
  localparam logic [7:0] RESET_CONFIG = 8'h00;

  typedef struct packed {
    logic [3:0] up;
    logic [3:0] down;
  } sbp_ramp_t;

  typedef struct packed {
    logic spare;
    logic [2:0] hold;
    logic [3:0] dark;
  } sbp_count_t;

  typedef struct packed {
    logic [1:0] current_range;
    logic [2:0] rsvd;
    logic slow;
    logic play;
    logic follow;
  } sbp_config_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 10;
  localparam int FRAME_TIME_US = 3330;
  localparam int FRAME_CYCLES = FRAME_TIME_US * CLK_MHZ;
  localparam int HOLD_UNIT_US = 106600;
  localparam logic [6:0] HOLD_UNIT_FRAMES = 7'(HOLD_UNIT_US / FRAME_TIME_US);
  localparam int DARK_UNIT_US = 320000;
  localparam logic [6:0] DARK_UNIT_FRAMES = 7'(DARK_UNIT_US / FRAME_TIME_US);
  localparam int MIN_TIME_US = 6700;
  localparam logic [11:0] MIN_FRAMES =
    12'((MIN_TIME_US + FRAME_TIME_US - 1) / FRAME_TIME_US);
  localparam int QUALIFY_US = 200;
  localparam int QUALIFY_CYCLES = QUALIFY_US * CLK_MHZ;
  localparam logic [4:0] LEVEL_FULL = 5'h1f;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RISE = 5'h02,
    ST_HOLD = 5'h04,
    ST_FALL = 5'h08,
    ST_DARK = 5'h10
  } sbp_state_t;

  typedef struct packed {
    sbp_state_t state;
    logic second;
    logic [4:0] level;
    logic [3:0] step;
    logic [11:0] wait_cnt;
    sbp_ramp_t ramp1;
    sbp_count_t count1;
    sbp_ramp_t ramp2;
    sbp_count_t count2;
    sbp_config_t cfg;
  } sbp_core_t;

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [11:0] cnt;
    logic held;
  } sbp_filter_t;
endpackage
`default_nettype wire

// File: logic/sbp_frame_tick.sv
`timescale 1ns/1ns
`default_nettype none
module sbp_frame_tick #(
  parameter int unsigned FRAME = 33300
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  output logic tick_out
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  always_comb
  begin
    next_cnt = (cnt == 16'h0000) ? 16'(FRAME - 1) : cnt - 16'h0001;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      cnt <= 16'h0000;
    else if (ce_in)
      cnt <= next_cnt;
  end

  // Gated by the enable so a frozen block sees no frame pass
  assign tick_out = ce_in && (cnt == 16'h0000);
endmodule
`default_nettype wire

// File: logic/sbp_line_filter.sv
`timescale 1ns/1ns
`default_nettype none
module sbp_line_filter #(
  parameter int unsigned QUAL = 2000
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic line_in,
  output logic level_out,
  output logic held_out
);
  import sbp_pkg::*;
  sbp_filter_t q;
  sbp_filter_t next_q;

  always_comb
  begin
    next_q = q;
    next_q.sync = {q.sync[1:0], line_in};
    // Second and third stages must agree before a change counts
    if (q.sync[2] == q.sync[1])
      next_q.level = q.sync[2];
    if (!q.level)
    begin
      next_q.cnt = 12'h000;
      next_q.held = 1'b0;
    end
    else if (q.cnt == 12'(QUAL - 1))
      next_q.held = 1'b1;
    else
      next_q.cnt = q.cnt + 12'h001;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      q <= '0;
    else if (ce_in)
      q <= next_q;
  end

  assign level_out = q.level;
  assign held_out = q.held;
endmodule
`default_nettype wire

// File: logic/sbp_pattern.sv
// Functional notes
// - Each ramp is 31 level steps, each held ramp count times one 3.33 ms frame.
// - A ramp count of zero jumps straight between off and full brightness.
// - Each pulse takes its rise and fall counts from its own ramp register.
// - Full brightness is held (slow+1) x hold count x 106.6 ms.
// - After a fall the LED stays dark (slow+1) x dark count x 320 ms.
// - Two pulses run with their own hold and ramp settings, split by dark gaps.
// - A hold count of zero holds the 6.7 ms floor on the first pulse and skips the second pulse.
// - The first pulse holds and stays dark for at least 6.7 ms.
// - The second pulse is skipped when its hold or dark count is zero.
// - With both second counts zero only first pulse timing is used.
// - First ramp register at address 0, reset 55, up 7:4, down 3:0.
// - First count register at address 1, reset 55, hold 6:4, dark 3:0.
// - Second count register at address 3 reset 00; second ramp at 2 reset 55.
// - Config at address 4: range 7:6, slow 2, play 1, follow 0.
// - Mode bits: none default, follow tracks the line, play repeats, both one-shot.
// - One-shot plays the first pulse after 200 us high, then repeats while high.
`timescale 1ns/1ns
`default_nettype none
module sbp_pattern #(
  parameter int unsigned FRAME_CYC = sbp_pkg::FRAME_CYCLES,
  parameter logic [7:0] CONFIG_RESET = sbp_pkg::RESET_CONFIG
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic ctrl_line_in,
  input wire logic reg_wr_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_data_in,
  output logic [4:0] pwm_level_out,
  output logic pulse_second_out,
  output logic pattern_active_out,
  output logic [1:0] current_range_out
);
  import sbp_pkg::*;

  sbp_core_t q;
  sbp_core_t next_q;
  logic tick;
  logic ctrl_level;
  logic ctrl_held;
  sbp_ramp_t ramp;
  sbp_count_t counts;
  logic p2_enable;
  logic follow_only;
  logic play_only;
  logic one_shot;
  logic default_mode;
  logic abort;
  logic [11:0] hold_target;
  logic [11:0] dark_target;

  // ****************************************
  // Frame base and line qualifier
  // ****************************************
  sbp_frame_tick #(
    .FRAME(FRAME_CYC)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_out(tick)
  );

  sbp_line_filter #(
    .QUAL(QUALIFY_CYCLES)
  ) u_filter (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .line_in(ctrl_line_in),
    .level_out(ctrl_level),
    .held_out(ctrl_held)
  );

  // ****************************************
  // Interval decode
  // ****************************************
  function automatic logic [11:0] span(input logic [3:0] n, input logic [6:0] unit,
                                       input logic slow);
    logic [11:0] p;
    p = 12'(n) * 12'(unit);
    return slow ? {p[10:0], 1'b0} : p;
  endfunction

  always_comb
  begin
    ramp = q.second ? q.ramp2 : q.ramp1;
    counts = q.second ? q.count2 : q.count1;
    p2_enable = (q.count2.hold != 3'h0) && (q.count2.dark != 4'h0);
    follow_only = q.cfg.follow && !q.cfg.play;
    play_only = q.cfg.play && !q.cfg.follow;
    one_shot = q.cfg.play && q.cfg.follow;
    default_mode = !q.cfg.play && !q.cfg.follow;
    abort = follow_only || (default_mode && !ctrl_level);
    hold_target = span({1'b0, counts.hold}, HOLD_UNIT_FRAMES, q.cfg.slow);
    dark_target = span(counts.dark, DARK_UNIT_FRAMES, q.cfg.slow);
    if (!q.second && hold_target < MIN_FRAMES)
      hold_target = MIN_FRAMES;
    if (!q.second && dark_target < MIN_FRAMES)
      dark_target = MIN_FRAMES;
  end

  // ****************************************
  // Pattern sequencer
  // ****************************************
  always_comb
  begin
    next_q = q;
    case (q.state)
      ST_IDLE:
      begin
        next_q.level = 5'h00;
        next_q.second = 1'b0;
        if (!follow_only && ctrl_held)
        begin
          next_q.state = ST_RISE;
          next_q.step = 4'h0;
        end
      end
      ST_RISE:
      begin
        if (q.level == LEVEL_FULL)
        begin
          next_q.step = 4'h0;
          if (hold_target == 12'h000)
            next_q.state = ST_FALL;
          else
          begin
            next_q.state = ST_HOLD;
            next_q.wait_cnt = hold_target;
          end
        end
        else if (ramp.up == 4'h0)
          next_q.level = LEVEL_FULL;
        else if (tick)
        begin
          if (q.step == ramp.up - 4'h1)
          begin
            next_q.step = 4'h0;
            next_q.level = q.level + 5'h01;
          end
          else
            next_q.step = q.step + 4'h1;
        end
      end
      ST_HOLD:
      begin
        if (tick)
        begin
          if (q.wait_cnt <= 12'h001)
          begin
            next_q.state = ST_FALL;
            next_q.step = 4'h0;
          end
          else
            next_q.wait_cnt = q.wait_cnt - 12'h001;
        end
      end
      ST_FALL:
      begin
        if (q.level == 5'h00)
        begin
          next_q.state = ST_DARK;
          next_q.wait_cnt = dark_target;
        end
        else if (ramp.down == 4'h0)
          next_q.level = 5'h00;
        else if (tick)
        begin
          if (q.step == ramp.down - 4'h1)
          begin
            next_q.step = 4'h0;
            next_q.level = q.level - 5'h01;
          end
          else
            next_q.step = q.step + 4'h1;
        end
      end
      ST_DARK:
      begin
        if (tick)
        begin
          if (q.wait_cnt > 12'h001)
            next_q.wait_cnt = q.wait_cnt - 12'h001;
          else if (!q.second && p2_enable && !one_shot)
          begin
            next_q.second = 1'b1;
            next_q.state = ST_RISE;
            next_q.step = 4'h0;
          end
          else
          begin
            next_q.second = 1'b0;
            next_q.step = 4'h0;
            next_q.state = (play_only || ctrl_level) ? ST_RISE : ST_IDLE;
          end
        end
      end
      default:
        next_q.state = ST_IDLE;
    endcase

    // One-shot is left alone here so a started pulse finishes
    if (abort)
    begin
      next_q.state = ST_IDLE;
      next_q.second = 1'b0;
      next_q.level = (follow_only && ctrl_level) ? LEVEL_FULL : 5'h00;
    end

    if (reg_wr_in)
    begin
      if (reg_addr_in == ADDR_RAMP1)
        next_q.ramp1 = reg_data_in;
      else if (reg_addr_in == ADDR_COUNT1)
        next_q.count1 = reg_data_in;
      else if (reg_addr_in == ADDR_RAMP2)
        next_q.ramp2 = reg_data_in;
      else if (reg_addr_in == ADDR_COUNT2)
        next_q.count2 = reg_data_in;
      else if (reg_addr_in == ADDR_CONFIG)
        next_q.cfg = reg_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q <= '0;
      q.state <= ST_IDLE;
      q.ramp1 <= RESET_RAMP1;
      q.count1 <= RESET_COUNT1;
      q.ramp2 <= RESET_RAMP2;
      q.count2 <= RESET_COUNT2;
      q.cfg <= CONFIG_RESET;
    end
    else if (ce_in)
      q <= next_q;
  end

  assign pwm_level_out = q.level;
  assign pulse_second_out = q.second;
  assign pattern_active_out = (q.state != ST_IDLE);
  assign current_range_out = q.cfg.current_range;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  sequence dark_done_s;
    q.state == ST_DARK && tick && q.wait_cnt <= 12'h001 && !abort;
  endsequence

  sequence first_wrap_s;
    !q.second && p2_enable && !one_shot && !reg_wr_in;
  endsequence

  rise_step_a: assert property (
    q.state == ST_RISE && tick && !abort && ramp.up != 4'h0 &&
    q.step == ramp.up - 4'h1 && q.level != LEVEL_FULL
    |=> q.level == $past(q.level) + 5'h01)
    else $error("rise step missed");

  zero_ramp_a: assert property (
    q.state == ST_RISE && ce_in && !abort && !reg_wr_in &&
    ramp.up == 4'h0 && q.level != LEVEL_FULL
    |=> q.level == LEVEL_FULL)
    else $error("zero ramp not direct");

  hold_len_a: assert property (
    q.state == ST_RISE && ce_in && !abort && q.level == LEVEL_FULL &&
    !q.second && !reg_wr_in
    |=> q.state == ST_HOLD && q.wait_cnt ==
      ((span({1'b0, q.count1.hold}, HOLD_UNIT_FRAMES, q.cfg.slow) < MIN_FRAMES) ?
        MIN_FRAMES : span({1'b0, q.count1.hold}, HOLD_UNIT_FRAMES, q.cfg.slow)))
    else $error("hold length wrong");

  dark_len_a: assert property (
    q.state == ST_FALL && ce_in && !abort && q.level == 5'h00 &&
    q.second && !reg_wr_in
    |=> q.state == ST_DARK &&
      q.wait_cnt == span(q.count2.dark, DARK_UNIT_FRAMES, q.cfg.slow))
    else $error("dark length wrong");

  pulse_order_a: assert property (
    dark_done_s ##0 first_wrap_s |=> q.state == ST_RISE && q.second)
    else $error("second pulse not entered");

  first_floor_a: assert property (
    $rose(q.state == ST_HOLD) && !q.second |-> q.wait_cnt >= MIN_FRAMES)
    else $error("first hold below floor");

  second_gate_a: assert property (
    $rose(q.second) |-> $past(p2_enable) && !$past(one_shot))
    else $error("disabled second pulse played");

  follow_track_a: assert property (
    follow_only && ce_in && !reg_wr_in
    |=> q.state == ST_IDLE && q.level == ($past(ctrl_level) ? LEVEL_FULL : 5'h00))
    else $error("follow level wrong");

  oneshot_first_a: assert property (
    one_shot && q.state == ST_DARK |-> !q.second ##1 !(q.second && one_shot))
    else $error("one-shot played second pulse");

  dark_floor_a: assert property (
    $rose(q.state == ST_DARK) && !q.second |-> q.wait_cnt >= MIN_FRAMES)
    else $error("first dark below floor");

  idle_level_a: assert property (
    default_mode && !ctrl_level && ce_in && !reg_wr_in
    |=> q.state == ST_IDLE && q.level == 5'h00)
    else $error("default stop missed");
endmodule
`default_nettype wire

// File: tb/sbp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Processor side: control line and words
// ****************************************
module sbp_host_model (
  input wire logic clk_sys_in,
  output logic ctrl_line_out,
  output logic reg_wr_out,
  output logic [2:0] reg_addr_out,
  output logic [7:0] reg_data_out
);
  initial
  begin
    ctrl_line_out = 1'b0;
    reg_wr_out = 1'b0;
    reg_addr_out = 3'h7;
    reg_data_out = 8'h00;
  end

  // Released bus shows the inverse so stale data never looks valid
  task automatic write_reg(input logic [2:0] addr, input logic [7:0] data);
    @(posedge clk_sys_in);
    #1;
    reg_wr_out = 1'b1;
    reg_addr_out = addr;
    reg_data_out = data;
    @(posedge clk_sys_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~addr;
    reg_data_out = ~data;
  endtask

  task automatic set_line(input logic level);
    @(posedge clk_sys_in);
    #1;
    ctrl_line_out = level;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sbp_pkg::*;
  // Short frame keeps the run small
  localparam int F = 20;
  typedef struct {
    logic all;
    logic [7:0] r1, c1, r2, c2, cfg;
    int step, top, bot;
    logic sec;
  } sbp_tb_row_t;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce = 1'b1;
  logic ctrl_line, reg_wr, pulse_second, pattern_active;
  logic [2:0] reg_addr;
  logic [7:0] reg_data;
  logic [4:0] pwm_level;
  logic [1:0] current_range;
  int errors = 0;
  int n_compared = 0;
  int n;
  sbp_tb_row_t rows[7] = '{
    '{1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 100, 3300, 9700, 1'b0},
    '{1'b1, 8'h11, 8'h11, 8'h55, 8'h00, 8'hc2, 20, 660, 1940, 1'b0},
    '{1'b1, 8'h21, 8'h00, 8'h55, 8'h00, 8'h02, 40, 80, 100, 1'b0},
    '{1'b1, 8'h11, 8'h11, 8'h55, 8'h00, 8'h46, 20, 1300, 3860, 1'b0},
    '{1'b1, 8'h11, 8'h11, 8'h31, 8'h11, 8'h02, 20, 660, 1980, 1'b1},
    '{1'b1, 8'h11, 8'h11, 8'h31, 8'h10, 8'h02, 20, 660, 1940, 1'b0},
    '{1'b1, 8'h11, 8'h11, 8'h31, 8'h11, 8'h83, 20, 660, 1940, 1'b0}
  };

  always #50 clk_sys_in = ~clk_sys_in;

  sbp_host_model host (.clk_sys_in(clk_sys_in), .ctrl_line_out(ctrl_line),
    .reg_wr_out(reg_wr), .reg_addr_out(reg_addr), .reg_data_out(reg_data));

  sbp_pattern #(.FRAME_CYC(F), .CONFIG_RESET(RESET_CONFIG)) DUT (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
    .ctrl_line_in(ctrl_line), .reg_wr_in(reg_wr), .reg_addr_in(reg_addr),
    .reg_data_in(reg_data), .pwm_level_out(pwm_level),
    .pulse_second_out(pulse_second), .pattern_active_out(pattern_active),
    .current_range_out(current_range));

  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Boundary cycles between phases allowed for
  task automatic check_span(input string what, input int exp, input int got);
    n_compared++;
    if (got < exp - 3 || got > exp + 3)
    begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Cycles spent at one level, after waiting for it
  task automatic span(input logic [4:0] lvl, output int cnt);
    int w;
    w = 0;
    cnt = 0;
    while (pwm_level !== lvl && w < 12000)
    begin
      @(posedge clk_sys_in);
      #2;
      w++;
    end
    while (pwm_level === lvl && cnt < 12000)
    begin
      @(posedge clk_sys_in);
      #2;
      cnt++;
    end
  endtask

  task automatic do_reset();
    host.set_line(1'b0);
    rst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
  endtask

  initial
  begin
    repeat (98000) @(posedge clk_sys_in);
    errors++;
    $display("mismatch watchdog expected done seen running");
    end_of_test();
  end

  initial
  begin
    // ****************************************
    // Table of programmed patterns
    // ****************************************
    foreach (rows[i])
    begin
      do_reset();
      if (rows[i].all)
      begin
        host.write_reg(ADDR_RAMP1, rows[i].r1);
        host.write_reg(ADDR_COUNT1, rows[i].c1);
        host.write_reg(ADDR_RAMP2, rows[i].r2);
        host.write_reg(ADDR_COUNT2, rows[i].c2);
      end
      host.write_reg(ADDR_CONFIG, rows[i].cfg);
      check_bits("range", {6'h0, rows[i].cfg[7:6]}, {6'h0, current_range});
      host.set_line(1'b1);
      span(5'h05, n);
      check_span("step", rows[i].step, n);
      span(LEVEL_FULL, n);
      check_span("top", rows[i].top, n);
      span(5'h00, n);
      check_span("bottom", rows[i].bot, n);
      check_bits("second", {7'h0, rows[i].sec}, {7'h0, pulse_second});
    end
    // ****************************************
    // Reset state and odd cases
    // ****************************************
    do_reset();
    check_bits("reset", 8'h00, {pattern_active, pulse_second, current_range, 
      pwm_level[3:0]});
    host.write_reg(ADDR_RAMP1, 8'h00);
    host.write_reg(ADDR_CONFIG, 8'h02);
    host.set_line(1'b1);
    span(5'h00, n);
    check_bits("jump up", 8'h1f, {3'h0, pwm_level});
    span(LEVEL_FULL, n);
    check_bits("jump down", 8'h00, {3'h0, pwm_level});
    do_reset();
    host.write_reg(3'h5, 8'hc0);
    host.write_reg(ADDR_CONFIG, 8'h01);
    host.set_line(1'b1);
    span(5'h00, n);
    check_span("follow on", 5, n);
    check_bits("follow", 8'h1f, {pattern_active, current_range, pwm_level});
    host.set_line(1'b0);
    span(LEVEL_FULL, n);
    check_span("follow off", 5, n);
    do_reset();
    host.set_line(1'b1);
    span(5'h00, n);
    host.set_line(1'b0);
    repeat (8) @(posedge clk_sys_in);
    #2;
    check_bits("abort", 8'h00, {2'h0, pattern_active, pwm_level});
    // Enable low: nothing moves and writes are lost
    do_reset();
    host.write_reg(ADDR_CONFIG, 8'h01);
    @(posedge clk_sys_in);
    #1;
    ce = 1'b0;
    host.write_reg(ADDR_CONFIG, 8'hc1);
    host.set_line(1'b1);
    repeat (10) @(posedge clk_sys_in);
    #2;
    check_bits("frozen", 8'h00, {1'b0, current_range, pwm_level});
    @(posedge clk_sys_in);
    #1;
    ce = 1'b1;
    repeat (8) @(posedge clk_sys_in);
    #2;
    check_bits("thawed", 8'h1f, {1'b0, current_range, pwm_level});
    end_of_test();
  end
endmodule
`default_nettype wire
